//--- pkg/pefs_consts.vh
// constants for the port e address pin function select block
`ifndef PEFS_CONSTS_VH
`define PEFS_CONSTS_VH

// ====================================================================
// register byte offsets on the avalon slave
`define PEFS_OFF_FSEL 4'h0
`define PEFS_OFF_DIR 4'h4
`define PEFS_OFF_DATA 4'h8
`define PEFS_OFF_STAT 4'hC

// ====================================================================
// field layout and reset values
`define PEFS_PIN_LO 5
`define PEFS_PIN_HI 14
`define PEFS_PIN_MASK 16'h7FE0
`define PEFS_FSEL_RESET 16'h0000
`define PEFS_DIR_RESET 16'h0000
`define PEFS_LATCH_RESET 16'h0000
`define PEFS_STAT_MODE_LSB 16
`define PEFS_RDATA_RESET 32'h0000_0000

// ====================================================================
// operating mode codes
`define PEFS_MODE_ROM_OFF 2'h0
`define PEFS_MODE_ROM_ON 2'h1
`define PEFS_MODE_SINGLE 2'h2
`define PEFS_MODE_SPARE 2'h3

`endif

//--- hw/pefs_pin_cell.v
// one multiplexed port e pin: function decode and registered pin drive
`timescale 1ns/10ps
`include "pefs_consts.vh"

module pefs_pin_cell (
  // clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // control
  input wire [1:0] op_mode,
  input wire fsel_bit,
  input wire dir_bit,
  input wire addr_bit,
  input wire latch_bit,
  // pin
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe_n,
  // status
  output wire is_addr,
  output reg pin_level
);

  // ====================================================================
  // function decode
  reg addr_sel;

  always @* begin
    case (op_mode)
      `PEFS_MODE_ROM_OFF: addr_sel = 1'b1;
      `PEFS_MODE_ROM_ON: addr_sel = fsel_bit;
      `PEFS_MODE_SINGLE: addr_sel = 1'b0;
      default: addr_sel = 1'b0;
    endcase
  end

  assign is_addr = addr_sel;

  // ====================================================================
  // pin drive; released during reset so nothing fights the board
  always @(posedge clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      pin_level <= 1'b0;
    end else if (ce) begin
      pin_level <= pin_in;
      if (addr_sel) begin
        pin_out <= addr_bit;
        pin_oe_n <= 1'b0;
      end else begin
        pin_out <= latch_bit;
        pin_oe_n <= ~dir_bit;
      end
    end
  end

endmodule // pefs_pin_cell

//--- hw/pefs_port_e_pinmux.v
// port e address pin function select: register slave and pin muxes
//
// Behaviour
// - rom-off expanded: all pins address outputs
// - rom-on expanded: bit 0 gpio, 1 address
// - single-chip: every pin stays gpio
// - select bits reset to zero
// - select bit n steers pin n, 14..5
// - power-on or hardware standby clears; else kept
// - gpio direction follows direction bit, 1 output
`timescale 1ns/10ps
`include "pefs_consts.vh"

module pefs_port_e_pinmux (
  // clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // chip state
  input wire [1:0] op_mode,
  input wire hw_standby,
  // avalon-mm slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // external bus address lines from the bus controller
  input wire [14:5] ext_addr,
  // port e pins 14..5
  input wire [14:5] pin_in,
  output wire [14:5] pin_out,
  output wire [14:5] pin_oe_n
);

  // ====================================================================
  // state
  reg [15:0] port_e_pin_function_select;
  reg [15:0] port_e_direction_select;
  reg [15:0] port_e_output_latch;
  reg ack;

  reg [15:0] next_fsel;
  reg [15:0] next_dir;
  reg [15:0] next_latch;
  reg [31:0] next_readdata;

  wire [14:5] pin_is_addr;
  wire [14:5] pin_level;
  wire [15:0] level_word;
  wire [15:0] addr_word;
  wire [31:0] stat_word;

  wire access;
  wire wr_now;
  wire rd_first;
  wire hit_fsel;
  wire hit_dir;
  wire hit_data;
  wire hit_stat;

  // ====================================================================
  // bus handshake
  // one wait cycle per access: the first cycle captures read data, the
  // second (ack high) is where waitrequest drops and writes land;
  // while ce is low the answer is held back, since a frozen edge would
  // let the master finish a write that never lands
  assign access = read | write;
  assign waitrequest = access & ~(ack & ce);
  assign wr_now = write & ~read & ack;
  assign rd_first = read & ~write & ~ack;

  assign hit_fsel = (address == `PEFS_OFF_FSEL);
  assign hit_dir = (address == `PEFS_OFF_DIR);
  assign hit_data = (address == `PEFS_OFF_DATA);
  assign hit_stat = (address == `PEFS_OFF_STAT);

  always @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= access & ~ack;
    end
  end

  // ====================================================================
  // byte-lane merge for the writable registers
  function [15:0] pefs_merge;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0] be;
    begin
      pefs_merge = old_val;
      if (be[0]) begin
        pefs_merge[7:0] = wdata[7:0];
      end
      if (be[1]) begin
        pefs_merge[15:8] = wdata[15:8];
      end
      pefs_merge = pefs_merge & `PEFS_PIN_MASK;
    end
  endfunction

  // ====================================================================
  // register write path
  // select bits are always writable, even where the mode ignores them
  always @* begin
    next_fsel = port_e_pin_function_select;
    next_dir = port_e_direction_select;
    next_latch = port_e_output_latch;
    if (wr_now && hit_fsel) begin
      next_fsel = pefs_merge(port_e_pin_function_select, writedata, byteenable);
    end
    if (wr_now && hit_dir) begin
      next_dir = pefs_merge(port_e_direction_select, writedata, byteenable);
    end
    if (wr_now && hit_data) begin
      next_latch = pefs_merge(port_e_output_latch, writedata, byteenable);
    end
  end

  // power-on reset and hardware standby clear; sleep and software
  // standby are simply ce low or no access, so contents are kept
  always @(posedge clk) begin
    if (rst) begin
      port_e_pin_function_select <= `PEFS_FSEL_RESET;
      port_e_direction_select <= `PEFS_DIR_RESET;
      port_e_output_latch <= `PEFS_LATCH_RESET;
    end else if (ce) begin
      if (hw_standby) begin
        port_e_pin_function_select <= `PEFS_FSEL_RESET;
        port_e_direction_select <= `PEFS_DIR_RESET;
        port_e_output_latch <= `PEFS_LATCH_RESET;
      end else begin
        port_e_pin_function_select <= next_fsel;
        port_e_direction_select <= next_dir;
        port_e_output_latch <= next_latch;
      end
    end
  end

  // ====================================================================
  // read path
  // readdata is captured in the wait cycle and held until the next read
  generate
    genvar w;
    for (w = 0; w < 16; w = w + 1) begin : g_word
      if (w >= `PEFS_PIN_LO && w <= `PEFS_PIN_HI) begin : g_pin
        assign level_word[w] = pin_level[w];
        assign addr_word[w] = pin_is_addr[w];
      end else begin : g_none
        assign level_word[w] = 1'b0;
        assign addr_word[w] = 1'b0;
      end
    end
  endgenerate

  assign stat_word = {14'h0000, op_mode, addr_word};

  always @* begin
    next_readdata = `PEFS_RDATA_RESET;
    case (address)
      `PEFS_OFF_FSEL: next_readdata = {16'h0000, port_e_pin_function_select};
      `PEFS_OFF_DIR: next_readdata = {16'h0000, port_e_direction_select};
      `PEFS_OFF_DATA: next_readdata = {16'h0000, level_word};
      `PEFS_OFF_STAT: next_readdata = stat_word;
      default: next_readdata = `PEFS_RDATA_RESET;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      readdata <= `PEFS_RDATA_RESET;
    end else if (ce && rd_first) begin
      readdata <= next_readdata;
    end
  end

  // ====================================================================
  // pin cells: select bit n drives pin n, which shares address line n
  generate
    genvar p;
    for (p = `PEFS_PIN_LO; p <= `PEFS_PIN_HI; p = p + 1) begin : g_pin_cell
      pefs_pin_cell u_cell (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .op_mode(op_mode),
        .fsel_bit(port_e_pin_function_select[p]),
        .dir_bit(port_e_direction_select[p]),
        .addr_bit(ext_addr[p]),
        .latch_bit(port_e_output_latch[p]),
        .pin_in(pin_in[p]),
        .pin_out(pin_out[p]),
        .pin_oe_n(pin_oe_n[p]),
        .is_addr(pin_is_addr[p]),
        .pin_level(pin_level[p])
      );
    end
  endgenerate

endmodule // pefs_port_e_pinmux

//--- verification/pefs_monitor.sv
// concurrent checks on the port e pin function select ports
`timescale 1ns/10ps
`include "pefs_consts.vh"

module pefs_monitor (
  // clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // chip state
  input wire [1:0] op_mode,
  input wire hw_standby,
  // avalon-mm
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  // pins
  input wire [14:5] ext_addr,
  input wire [14:5] pin_out,
  input wire [14:5] pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // sequences
  sequence s_romoff;
    ce && op_mode == `PEFS_MODE_ROM_OFF;
  endsequence
  // three quiet cycles let any earlier write drain through the pin flops
  sequence s_quiet;
    (ce && !write && !hw_standby && op_mode[1])[*3];
  endsequence
  // ==========================================
  // properties
  property p_romoff;
    s_romoff |=> pin_oe_n == 10'h000 && pin_out == $past(ext_addr);
  endproperty
  a_romoff: assert property (p_romoff) else $error("address function missing");
  property p_single;
    s_quiet |=> $stable(pin_out) && $stable(pin_oe_n);
  endproperty
  a_single: assert property (p_single) else $error("single-chip pins moved");
  property p_reset;
    disable iff (1'b0) rst |=> pin_oe_n == 10'h3FF && readdata == `PEFS_RDATA_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_idle;
    !read && !write |-> !waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("wait without request");
  property p_wait;
    (read || write) && waitrequest && ce |=> !waitrequest || !(read || write) || !ce;
  endproperty
  a_wait: assert property (p_wait) else $error("answer late");
  property p_ack;
    (read || write) && !waitrequest && ce |=> waitrequest || !(read || write);
  endproperty
  a_ack: assert property (p_ack) else $error("answer held");
  property p_pad;
    read && !waitrequest |-> readdata[31:18] == 14'h0000 && readdata[4:0] == 5'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("unused bits set");
  property p_stat;
    read && !waitrequest && $past(waitrequest) && address == `PEFS_OFF_STAT |-> readdata[17:16] == $past(op_mode);
  endproperty
  a_stat: assert property (p_stat) else $error("status mode wrong");
endmodule // pefs_monitor

bind pefs_port_e_pinmux pefs_monitor mon (.clk, .rst, .ce, .op_mode, .hw_standby, .address, .read, .write,
  .readdata, .waitrequest, .ext_addr, .pin_out, .pin_oe_n);

//--- verification/testbench.sv
// self-checking bench for port e pin function select
`timescale 1ns/10ps
`include "pefs_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module testbench;
  reg clk = 0, rst = 1, ce = 1, hw_standby = 0, read = 0, write = 0;
  reg [1:0] op_mode = 0;
  reg [3:0] address = 0;
  reg [31:0] writedata = 0;
  reg [31:0] q;
  reg [9:0] ext_addr = 0, pin_in = 0;
  wire [31:0] readdata;
  wire waitrequest;
  wire [9:0] pin_out, pin_oe_n;
  integer num_errors = 0, num_checks = 0, cyc = 0, n;

  pefs_port_e_pinmux uut (.clk, .rst, .ce, .op_mode, .hw_standby, .address, .read, .write, .writedata,
    .byteenable(4'hF), .readdata, .waitrequest, .ext_addr, .pin_in, .pin_out, .pin_oe_n);

  initial forever #50 clk = ~clk;
  // ==========================================
  // bus and pin helpers
  task bus(input wr, input [3:0] a, input [15:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {16'h0000, d};
    // waitrequest is read at each rising edge before any flop of the edge moves
    do @(posedge clk); while (waitrequest);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rd(input [3:0] a, input [31:0] e);
    bus(0, a, 16'h0000);
    `CHK(q, e)
  endtask
  task set(input [1:0] m, input [9:0] ea);
    @(posedge clk);
    op_mode <= m;
    ext_addr <= ea;
  endtask
  task pins(input [9:0] oe, input [9:0] o);
    repeat (2) @(posedge clk);
    #1;
    `CHK(pin_oe_n, oe)
    `CHK(pin_out, o)
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    rd(`PEFS_OFF_FSEL, `PEFS_RDATA_RESET);
    rd(`PEFS_OFF_DIR, `PEFS_RDATA_RESET);
    set(`PEFS_MODE_ROM_OFF, 10'h2A5);
    pins(10'h000, 10'h2A5);
  endtask
  task t_rom_off;
    bus(1, `PEFS_OFF_FSEL, 16'hFFFF);
    set(`PEFS_MODE_ROM_OFF, 10'h15A);
    pins(10'h000, 10'h15A);
    rd(`PEFS_OFF_FSEL, {16'h0000, `PEFS_PIN_MASK});
  endtask
  task t_rom_on;
    bus(1, `PEFS_OFF_DIR, `PEFS_PIN_MASK);
    bus(1, `PEFS_OFF_DATA, 16'h0000);
    set(`PEFS_MODE_ROM_ON, 10'h3FF);
    for (n = 5; n <= 14; n++) begin
      bus(1, `PEFS_OFF_FSEL, 16'h0001 << n);
      pins(10'h000, 10'h001 << (n - 5));
    end
    bus(1, `PEFS_OFF_DIR, 16'h0000);
    bus(1, `PEFS_OFF_FSEL, 16'h0020);
    pins(10'h3FE, 10'h001);
  endtask
  task t_single;
    bus(1, `PEFS_OFF_FSEL, 16'hFFFF);
    bus(1, `PEFS_OFF_DIR, `PEFS_PIN_MASK);
    bus(1, `PEFS_OFF_DATA, 16'h2AA0);
    for (n = 2; n <= 3; n++) begin
      set(n[1:0], 10'h0F0 + n[9:0]);
      pins(10'h000, 10'h155);
      rd(`PEFS_OFF_FSEL, {16'h0000, `PEFS_PIN_MASK});
      rd(`PEFS_OFF_STAT, {14'h0000, n[1:0], 16'h0000});
    end
  endtask
  task t_standby;
    @(posedge clk);
    pin_in <= 10'h2B3;
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    rd(`PEFS_OFF_FSEL, `PEFS_RDATA_RESET);
    pins(10'h3FF, 10'h000);
    rd(`PEFS_OFF_DATA, 32'h0000_5660);
    bus(1, 4'h2, 16'hFFFF);
    rd(4'h2, `PEFS_RDATA_RESET);
    rd(`PEFS_OFF_FSEL, `PEFS_RDATA_RESET);
  endtask
  task t_freeze;
    bus(1, `PEFS_OFF_FSEL, 16'h1234);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd(`PEFS_OFF_FSEL, 32'h0000_1220);
    // ce drops just as the ack flop sets: the write must wait, not vanish
    fork
      bus(1, `PEFS_OFF_FSEL, 16'h0000);
      begin
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    rd(`PEFS_OFF_FSEL, `PEFS_RDATA_RESET);
  endtask
  // ==========================================
  // run control
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // the full run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rom_off;
    t_rom_on;
    t_single;
    t_standby;
    t_freeze;
    wrap_up;
  end
endmodule // testbench
